/* logic/lci_pkg.sv */
package lci_pkg;
  // sample and delay geometry
  localparam int SAMPLE_W = 16;
  localparam int DELAY_STEPS = 16;
  localparam int DELAY_W = 4;
  localparam int ACC_W = 40;
  localparam int HALF_W = 6;
  localparam int PERIOD_W = 8;

  // timing: core clock, settle time after calibration, host link divider
  localparam int CORE_CLK_PERIOD_NS = 100;
  localparam int OPER_TIME_NS = 30000;
  localparam int OPER_CYCLES = (OPER_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int OPER_W = $clog2(OPER_CYCLES + 1);
  localparam int LINK_HALF_CYCLES = 4;
  localparam int DIV_W = 3;
  // silicon limits; a 10 MHz model never approaches them
  localparam int MAX_UPDATE_MSPS = 1000;
  localparam int MAX_DATA_RATE_MHZ = 370;

  // host register map, byte addresses on the plain port
  localparam int REG_W = 32;
  localparam int HOST_ADDR_W = 4;
  localparam logic [HOST_ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [HOST_ADDR_W-1:0] SAMPLE_OFS = 4'h4;
  localparam logic [HOST_ADDR_W-1:0] STATUS_OFS = 4'h8;
  localparam logic [REG_W-1:0] CTRL_RESET = 32'h0000_3000;
  localparam logic [REG_W-1:0] SAMPLE_RESET = 32'h0000_0000;
  localparam int CTRL_TUNE_BIT = 0;
  localparam int CTRL_DELAY_LSB = 4;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_CORE_RST_BIT = 12;
  localparam int CTRL_LINK_RST_BIT = 13;
  localparam int CTRL_LINK_EN_BIT = 14;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_CAL_BIT = 1;
  localparam int STAT_DELAY_LSB = 4;
  localparam int SAMPLE_B_LSB = 16;

  typedef enum logic [1:0] {LCI_RATIO_X2, LCI_RATIO_X4, LCI_RATIO_X8, LCI_RATIO_RSVD} lci_ratio_t;
  typedef enum logic {LCI_TUNE_AUTO, LCI_TUNE_MANUAL} lci_tune_t;
  typedef enum logic [1:0] {CAL_WAIT_EDGE, CAL_MEASURE, CAL_DONE} lci_cal_state_t;

  // halfband coefficients, odd offsets from centre; centres are powers of two
  localparam int FIR1_COEF [14] = '{41501, -13258, 7302, -4580, 2987, -1951, 1250,
                                    -773, 456, -252, 128, -58, 22, -6};
  localparam int FIR2_COEF [6] = '{20272, -5358, 1986, -654, 159, -21};
  localparam int FIR3_COEF [4] = '{615, -127, 27, -3};
  localparam int FIR1_SHIFT = 16;
  localparam int FIR2_SHIFT = 15;
  localparam int FIR3_SHIFT = 10;
  localparam logic signed [ACC_W-1:0] SAT_HI = 40'sh00_0000_7FFF;
  localparam logic signed [ACC_W-1:0] SAT_LO = 40'shFF_FFFF_8000;

  function automatic int lci_pairs(input int stage);
    return (stage == 1) ? 14 : (stage == 2) ? 6 : 4;
  endfunction

  function automatic int lci_shift(input int stage);
    return (stage == 1) ? FIR1_SHIFT : (stage == 2) ? FIR2_SHIFT : FIR3_SHIFT;
  endfunction

  function automatic int lci_coef(input int stage, input int j);
    return (stage == 1) ? FIR1_COEF[j] : (stage == 2) ? FIR2_COEF[j] : FIR3_COEF[j];
  endfunction

  // clip a normalised sum back into the sample range
  function automatic logic signed [SAMPLE_W-1:0] lci_sat(input logic signed [ACC_W-1:0] v);
    if (v > SAT_HI) return SAT_HI[SAMPLE_W-1:0];
    if (v < SAT_LO) return SAT_LO[SAMPLE_W-1:0];
    return v[SAMPLE_W-1:0];
  endfunction

  // log2 of the upsampling ratio of a mode
  function automatic logic [1:0] lci_ratio_log2(input lci_ratio_t r);
    return (r == LCI_RATIO_X2) ? 2'h1 : (r == LCI_RATIO_X4) ? 2'h2 : 2'h3;
  endfunction
endpackage

/* logic/lci_link_if.sv */
`timescale 1ns/1ps
interface lci_link_if;
  import lci_pkg::*;
  logic link_clock_pos;
  logic link_clock_neg;
  logic [SAMPLE_W-1:0] link_data;
  lci_tune_t tuning_mode_select;
  logic [DELAY_W-1:0] manual_sample_delay;
  lci_ratio_t domain_crossing_mode;
  lci_ratio_t interp_select;
  logic core_domain_reset;
  logic link_domain_reset;
  logic dev_ready;
  logic cal_done;
  logic [DELAY_W-1:0] applied_delay;

  modport device (
    input link_clock_pos, link_clock_neg, link_data, tuning_mode_select,
    input manual_sample_delay, domain_crossing_mode, interp_select,
    input core_domain_reset, link_domain_reset,
    output dev_ready, cal_done, applied_delay
  );
  modport host (
    output link_clock_pos, link_clock_neg, link_data, tuning_mode_select,
    output manual_sample_delay, domain_crossing_mode, interp_select,
    output core_domain_reset, link_domain_reset,
    input dev_ready, cal_done, applied_delay
  );
endinterface

/* logic/lci_host.sv */
`timescale 1ns/1ps
module lci_host (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic [lci_pkg::HOST_ADDR_W-1:0] ADDR_IN,
  input wire logic [lci_pkg::REG_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [lci_pkg::REG_W-1:0] RDATA_OUT,
  lci_link_if.host LINK
);
  import lci_pkg::*;

  logic [REG_W-1:0] ctrl_r;
  logic [REG_W-1:0] sample_r;
  logic [DIV_W-1:0] div_r;
  logic clk_r;
  logic clk_n_r;
  logic [SAMPLE_W-1:0] data_r;
  logic [SAMPLE_W-1:0] b_hold_r;
  logic wrap;

  // control and sample registers; resets start asserted so calibration waits for software
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      ctrl_r <= CTRL_RESET;
      sample_r <= SAMPLE_RESET;
    end else if (WR_IN) begin
      if (ADDR_IN == CTRL_OFS) begin
        ctrl_r <= WDATA_IN;
      end else if (ADDR_IN == SAMPLE_OFS) begin
        sample_r <= WDATA_IN;
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere and for unmapped addresses
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      RDATA_OUT <= '0;
    end else if (RD_IN) begin
      if (ADDR_IN == CTRL_OFS) begin
        RDATA_OUT <= ctrl_r;
      end else if (ADDR_IN == SAMPLE_OFS) begin
        RDATA_OUT <= sample_r;
      end else if (ADDR_IN == STATUS_OFS) begin
        RDATA_OUT <= '0;
        RDATA_OUT[STAT_READY_BIT] <= LINK.dev_ready;
        RDATA_OUT[STAT_CAL_BIT] <= LINK.cal_done;
        RDATA_OUT[STAT_DELAY_LSB +: DELAY_W] <= LINK.applied_delay;
      end else begin
        RDATA_OUT <= '0;
      end
    end else begin
      RDATA_OUT <= '0;
    end
  end

  assign wrap = (div_r == DIV_W'(LINK_HALF_CYCLES - 1));

  // link clock divider; a disabled clock is parked low so it never ends on a short half
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      div_r <= '0;
      clk_r <= 1'b0;
      clk_n_r <= 1'b1;
      data_r <= '0;
      b_hold_r <= '0;
    end else begin
      div_r <= wrap ? '0 : div_r + 3'h1;
      if (wrap && (ctrl_r[CTRL_LINK_EN_BIT] || clk_r)) begin
        clk_r <= !clk_r;
        // complement kept in its own flop so both pins leave the block registered
        clk_n_r <= clk_r;
        // data changes with every clock edge, A after rising, B after falling
        if (!clk_r) begin
          data_r <= sample_r[SAMPLE_W-1:0];
          b_hold_r <= sample_r[SAMPLE_B_LSB +: SAMPLE_W];
        end else begin
          data_r <= b_hold_r;
        end
      end
    end
  end

  // link clock pair plus the shared core clock form the two clocks
  assign LINK.link_clock_pos = clk_r;
  assign LINK.link_clock_neg = clk_n_r;
  assign LINK.link_data = data_r;
  assign LINK.tuning_mode_select = lci_tune_t'(ctrl_r[CTRL_TUNE_BIT]);
  assign LINK.manual_sample_delay = ctrl_r[CTRL_DELAY_LSB +: DELAY_W];
  assign LINK.domain_crossing_mode = lci_ratio_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  // interpolation follows the mode field, so the pair can never disagree
  assign LINK.interp_select = lci_ratio_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign LINK.core_domain_reset = ctrl_r[CTRL_CORE_RST_BIT];
  assign LINK.link_domain_reset = ctrl_r[CTRL_LINK_RST_BIT];
  // divider is fixed, so the derived core rate never exceeds the core clock and equals it in x8 mode
endmodule

/* logic/lci_device.sv */
`timescale 1ns/1ps
module lci_halfband #(
  parameter int STAGE = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic signed [lci_pkg::SAMPLE_W-1:0] feed_a_in,
  input wire logic signed [lci_pkg::SAMPLE_W-1:0] feed_b_in,
  output logic odd_out,
  output logic signed [lci_pkg::SAMPLE_W-1:0] out_a_out,
  output logic signed [lci_pkg::SAMPLE_W-1:0] out_b_out
);
  import lci_pkg::*;
  localparam int NP = lci_pairs(STAGE);
  localparam int SH = lci_shift(STAGE);

  logic signed [SAMPLE_W-1:0] hist_a_r [2*NP];
  logic signed [SAMPLE_W-1:0] hist_b_r [2*NP];
  logic signed [ACC_W-1:0] acc_a;
  logic signed [ACC_W-1:0] acc_b;

  // only odd taps are nonzero, so each output needs just the symmetric pairs
  always_comb begin
    acc_a = '0;
    acc_b = '0;
    for (int j = 0; j < NP; j++) begin
      acc_a = acc_a + ACC_W'(lci_coef(STAGE, j)) *
              (ACC_W'(hist_a_r[NP-1-j]) + ACC_W'(hist_a_r[NP+j]));
      acc_b = acc_b + ACC_W'(lci_coef(STAGE, j)) *
              (ACC_W'(hist_b_r[NP-1-j]) + ACC_W'(hist_b_r[NP+j]));
    end
  end

  // history shifts once per input, on the even phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2*NP; i++) begin
        hist_a_r[i] <= '0;
        hist_b_r[i] <= '0;
      end
    end else if (en_in && !odd_out) begin
      hist_a_r[0] <= feed_a_in;
      hist_b_r[0] <= feed_b_in;
      for (int i = 1; i < 2*NP; i++) begin
        hist_a_r[i] <= hist_a_r[i-1];
        hist_b_r[i] <= hist_b_r[i-1];
      end
    end
  end

  // even phase passes the centre sample, odd phase the normalised sum
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      odd_out <= 1'b0;
      out_a_out <= '0;
      out_b_out <= '0;
    end else if (en_in) begin
      odd_out <= !odd_out;
      if (!odd_out) begin
        out_a_out <= hist_a_r[NP-1];
        out_b_out <= hist_b_r[NP-1];
      end else begin
        out_a_out <= lci_sat(acc_a >>> SH); // divide by centre tap
        out_b_out <= lci_sat(acc_b >>> SH);
      end
    end
  end
endmodule

module lci_device (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  lci_link_if.device LINK,
  output logic signed [lci_pkg::SAMPLE_W-1:0] SAMPLE_A_OUT,
  output logic signed [lci_pkg::SAMPLE_W-1:0] SAMPLE_B_OUT,
  output logic SAMPLE_VALID_OUT,
  output logic READY_OUT
);
  import lci_pkg::*;

  logic link_rst;
  logic core_rst;
  logic [SAMPLE_W:0] sync1_r;
  logic [SAMPLE_W:0] sync2_r;
  logic [SAMPLE_W:0] sync3_r;
  logic [SAMPLE_W:0] pin_r;
  logic prev_clk_r;
  logic rise;
  logic fall;
  logic [DELAY_STEPS-2:0] rise_dly_r;
  logic [DELAY_STEPS-2:0] fall_dly_r;
  lci_cal_state_t cal_r;
  logic [HALF_W-1:0] half_r;
  logic [HALF_W-1:0] half_nxt;
  logic [DELAY_W-1:0] delay_r;
  logic cal_done_r;
  logic [SAMPLE_W-1:0] word_a_r;
  logic signed [SAMPLE_W-1:0] pair_a_r;
  logic signed [SAMPLE_W-1:0] pair_b_r;
  logic pair_new_r;
  logic [PERIOD_W-1:0] per_cnt_r;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W-1:0] spacing;
  logic [PERIOD_W-1:0] gap_r;
  logic [3:0] left_r;
  logic tick;
  logic use4;
  logic use8;
  logic en1;
  logic en2;
  logic en3;
  logic odd1;
  logic odd2;
  logic odd3;
  logic signed [SAMPLE_W-1:0] s1_a;
  logic signed [SAMPLE_W-1:0] s1_b;
  logic signed [SAMPLE_W-1:0] s2_a;
  logic signed [SAMPLE_W-1:0] s2_b;
  logic signed [SAMPLE_W-1:0] s3_a;
  logic signed [SAMPLE_W-1:0] s3_b;
  logic tick_d_r;
  logic [OPER_W-1:0] oper_r;

  // picks the edge flag delayed by d cycles; d of zero means the edge itself
  function automatic logic lci_tap(input logic now, input logic [DELAY_STEPS-2:0] line,
                                   input logic [DELAY_W-1:0] d);
    return (d == '0) ? now : line[d - 4'h1];
  endfunction

  assign link_rst = RESET_IN || LINK.link_domain_reset;
  assign core_rst = RESET_IN || LINK.core_domain_reset;

  // link clock and data pass three stages and settle once the last two agree
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      pin_r <= '0;
      prev_clk_r <= 1'b0;
    end else begin
      sync1_r <= {LINK.link_clock_pos, LINK.link_data};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        pin_r <= sync3_r;
      end
      prev_clk_r <= pin_r[SAMPLE_W];
    end
  end

  assign rise = pin_r[SAMPLE_W] && !prev_clk_r;
  assign fall = !pin_r[SAMPLE_W] && prev_clk_r;

  // edge flags run down sixteen-step delay lines; the tap is the sampling strobe
  always_ff @(posedge CORE_CLK_IN) begin
    if (link_rst) begin
      rise_dly_r <= '0;
      fall_dly_r <= '0;
    end else begin
      rise_dly_r <= {rise_dly_r[DELAY_STEPS-3:0], rise};
      fall_dly_r <= {fall_dly_r[DELAY_STEPS-3:0], fall};
    end
  end

  assign half_nxt = (half_r == '1) ? half_r : half_r + 6'h01;

  // calibration: manual takes the field, auto centres the strobe in a measured half period
  always_ff @(posedge CORE_CLK_IN) begin
    if (link_rst) begin
      cal_r <= CAL_WAIT_EDGE;
      half_r <= '0;
      delay_r <= '0;
      cal_done_r <= 1'b0;
    end else begin
      case (cal_r)
        CAL_WAIT_EDGE: begin
          if (LINK.tuning_mode_select == LCI_TUNE_MANUAL) begin
            delay_r <= LINK.manual_sample_delay;
            cal_r <= CAL_DONE;
          end else if (rise || fall) begin
            half_r <= 6'h01;
            cal_r <= CAL_MEASURE;
          end
        end
        CAL_MEASURE: begin
          if (rise || fall) begin
            // clock toggles with data, so half a half-period lands mid-eye
            delay_r <= (half_r[HALF_W-1]) ? '1 : half_r[DELAY_W:1];
            cal_r <= CAL_DONE;
          end else begin
            half_r <= half_nxt;
          end
        end
        default: begin
          cal_done_r <= 1'b1;
          // manual edits track live; returning to auto needs a link reset
          if (LINK.tuning_mode_select == LCI_TUNE_MANUAL) begin
            delay_r <= LINK.manual_sample_delay;
          end
        end
      endcase
    end
  end

  // capture A on delayed rising strobe, B on delayed falling strobe, then hand over the pair
  always_ff @(posedge CORE_CLK_IN) begin
    if (link_rst) begin
      word_a_r <= '0;
      pair_a_r <= '0;
      pair_b_r <= '0;
      pair_new_r <= 1'b0;
    end else begin
      pair_new_r <= 1'b0;
      if (cal_done_r && lci_tap(rise, rise_dly_r, delay_r)) begin
        word_a_r <= pin_r[SAMPLE_W-1:0];
      end
      if (cal_done_r && lci_tap(fall, fall_dly_r, delay_r)) begin
        pair_a_r <= word_a_r;
        pair_b_r <= pin_r[SAMPLE_W-1:0];
        pair_new_r <= 1'b1;
      end
    end
  end

  // pair period measured in core cycles; the count saturates at 255, and the period then wraps to zero
  always_ff @(posedge CORE_CLK_IN) begin
    if (core_rst) begin
      per_cnt_r <= '0;
      period_r <= '0;
    end else if (pair_new_r) begin
      period_r <= per_cnt_r + 8'h01;
      per_cnt_r <= '0;
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + 8'h01;
    end
  end

  // tick spacing is the pair period divided by the mode ratio, never below one cycle
  always_comb begin
    spacing = period_r >> lci_ratio_log2(LINK.domain_crossing_mode);
    if (spacing == '0) begin
      spacing = 8'h01;
    end
  end

  // each pair starts a burst of ratio ticks; this multiplies link rate to core rate
  always_ff @(posedge CORE_CLK_IN) begin
    if (core_rst) begin
      left_r <= '0;
      gap_r <= '0;
    end else if (pair_new_r) begin
      left_r <= 4'h1 << lci_ratio_log2(LINK.domain_crossing_mode);
      gap_r <= '0;
    end else if (left_r != '0) begin
      if (gap_r == '0) begin
        left_r <= left_r - 4'h1;
        gap_r <= spacing - 8'h01;
      end else begin
        gap_r <= gap_r - 8'h01;
      end
    end
  end

  assign tick = (left_r != '0) && (gap_r == '0);

  // stages cascade; an upstream stage steps while its consumer computes an odd sample
  assign use4 = (LINK.interp_select != LCI_RATIO_X2);
  assign use8 = (LINK.interp_select == LCI_RATIO_X8);
  assign en3 = tick && use8;
  assign en2 = use8 ? (en3 && odd3) : (tick && use4);
  assign en1 = use4 ? (en2 && odd2) : tick;

  lci_halfband #(.STAGE(1)) u_fir1 (
    .clk_in(CORE_CLK_IN),
    .rst_in(core_rst),
    .en_in(en1),
    .feed_a_in(pair_a_r),
    .feed_b_in(pair_b_r),
    .odd_out(odd1),
    .out_a_out(s1_a),
    .out_b_out(s1_b)
  );

  lci_halfband #(.STAGE(2)) u_fir2 (
    .clk_in(CORE_CLK_IN),
    .rst_in(core_rst),
    .en_in(en2),
    .feed_a_in(s1_a),
    .feed_b_in(s1_b),
    .odd_out(odd2),
    .out_a_out(s2_a),
    .out_b_out(s2_b)
  );

  lci_halfband #(.STAGE(3)) u_fir3 (
    .clk_in(CORE_CLK_IN),
    .rst_in(core_rst),
    .en_in(en3),
    .feed_a_in(s2_a),
    .feed_b_in(s2_b),
    .odd_out(odd3),
    .out_a_out(s3_a),
    .out_b_out(s3_b)
  );

  // output register one cycle after the last stage updates; odd1 is phase only
  always_ff @(posedge CORE_CLK_IN) begin
    if (core_rst) begin
      tick_d_r <= 1'b0;
      SAMPLE_A_OUT <= '0;
      SAMPLE_B_OUT <= '0;
      SAMPLE_VALID_OUT <= 1'b0;
    end else begin
      tick_d_r <= tick;
      SAMPLE_VALID_OUT <= tick_d_r;
      if (tick_d_r) begin
        SAMPLE_A_OUT <= use8 ? s3_a : (use4 ? s2_a : s1_a);
        SAMPLE_B_OUT <= use8 ? s3_b : (use4 ? s2_b : s1_b);
      end
    end
  end

  // settle counter after calibration before declaring the path operational
  always_ff @(posedge CORE_CLK_IN) begin
    if (core_rst || !cal_done_r) begin
      oper_r <= '0;
      READY_OUT <= 1'b0;
    end else if (oper_r == OPER_W'(OPER_CYCLES)) begin
      READY_OUT <= 1'b1;
    end else begin
      oper_r <= oper_r + 9'h001;
    end
  end

  assign LINK.dev_ready = READY_OUT;
  assign LINK.cal_done = cal_done_r;
  assign LINK.applied_delay = delay_r;
endmodule

/* sim/lci_props.sv */
`timescale 1ns/1ps
module lci_props (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic link_clock_pos,
  input wire logic link_clock_neg,
  input wire logic [lci_pkg::SAMPLE_W-1:0] link_data,
  input wire lci_pkg::lci_tune_t tuning_mode_select,
  input wire logic [lci_pkg::DELAY_W-1:0] manual_sample_delay,
  input wire lci_pkg::lci_ratio_t domain_crossing_mode,
  input wire lci_pkg::lci_ratio_t interp_select,
  input wire logic core_domain_reset,
  input wire logic link_domain_reset,
  input wire logic dev_ready,
  input wire logic cal_done,
  input wire logic [lci_pkg::DELAY_W-1:0] applied_delay
);
  import lci_pkg::*;
  // one domain only, so clock and reset are given once
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);

  // the bench never parks the link clock once enabled, so every phase is exactly four cycles
  property p_half_hi;
    $rose(link_clock_pos) |-> link_clock_pos [*4] ##1 !link_clock_pos;
  endproperty
  a_half_hi: assert property (p_half_hi) else $error("link clock high phase wrong");
  property p_half_lo;
    $fell(link_clock_pos) |-> !link_clock_pos [*4] ##1 link_clock_pos;
  endproperty
  a_half_lo: assert property (p_half_lo) else $error("link clock low phase wrong");
  // data may only move together with a clock edge
  property p_data_edge;
    $changed(link_data) |-> $changed(link_clock_pos);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved off edge");
  property p_neg_comp;
    link_clock_neg == !link_clock_pos;
  endproperty
  a_neg_comp: assert property (p_neg_comp) else $error("link clock pair not complementary");
  property p_interp;
    interp_select == domain_crossing_mode;
  endproperty
  a_interp: assert property (p_interp) else $error("interpolation differs from mode");
  property p_cal_rst;
    link_domain_reset [*2] |-> !cal_done;
  endproperty
  a_cal_rst: assert property (p_cal_rst) else $error("calibrated under link reset");
  // ready only after the full settle time and with the core side released
  property p_ready_wait;
    $rose(dev_ready) |-> cal_done && $past(cal_done, 300) && !core_domain_reset;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready too early");
  property p_manual;
    (cal_done && tuning_mode_select == LCI_TUNE_MANUAL && $stable(manual_sample_delay)) [*4]
      |-> applied_delay == manual_sample_delay;
  endproperty
  a_manual: assert property (p_manual) else $error("manual delay not applied");
  // half of the four-cycle half period measured on the link
  property p_auto;
    cal_done && tuning_mode_select == LCI_TUNE_AUTO |-> applied_delay == 4'h2;
  endproperty
  a_auto: assert property (p_auto) else $error("automatic delay wrong");

  c_ready: cover property ($rose(dev_ready));
  c_manual: cover property (cal_done && tuning_mode_select == LCI_TUNE_MANUAL);
  c_x8: cover property (dev_ready && domain_crossing_mode == LCI_RATIO_X8);
endmodule

/* sim/lvds_capture_cdi_interpolation_test.sv */
`timescale 1ns/1ps
module lvds_capture_cdi_interpolation_test;
  import lci_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [HOST_ADDR_W-1:0] addr = '0;
  logic [REG_W-1:0] wdata = '0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic rd_q = 1'h0;
  logic [REG_W-1:0] rdata;
  logic signed [SAMPLE_W-1:0] sa;
  logic signed [SAMPLE_W-1:0] sb;
  logic sv;
  logic rdy;
  int num_errors = 0;
  int n_compared = 0;
  int vcnt = 0;
  logic [REG_W-1:0] exp_r[$];
  logic [REG_W-1:0] exp_s[$];

  always #50 clk = ~clk;

  lci_link_if lnk ();
  lci_host u_lci_host (.CORE_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LINK(lnk));
  lci_device u_lci_device (.CORE_CLK_IN(clk), .RESET_IN(rst), .LINK(lnk), .SAMPLE_A_OUT(sa),
    .SAMPLE_B_OUT(sb), .SAMPLE_VALID_OUT(sv), .READY_OUT(rdy));
  lci_props u_lci_props (.CORE_CLK_IN(clk), .RESET_IN(rst),
    .link_clock_pos(lnk.link_clock_pos), .link_clock_neg(lnk.link_clock_neg),
    .link_data(lnk.link_data), .tuning_mode_select(lnk.tuning_mode_select),
    .manual_sample_delay(lnk.manual_sample_delay),
    .domain_crossing_mode(lnk.domain_crossing_mode), .interp_select(lnk.interp_select),
    .core_domain_reset(lnk.core_domain_reset), .link_domain_reset(lnk.link_domain_reset),
    .dev_ready(lnk.dev_ready), .cal_done(lnk.cal_done), .applied_delay(lnk.applied_delay));

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_val(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_smp(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t sample got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a gap cycle after each strobe keeps one assignment per signal per step
  task automatic wr_reg(input logic [HOST_ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [HOST_ADDR_W-1:0] a, input logic [REG_W-1:0] e);
    exp_r.push_back(e);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe; samples match oldest note first
  always @(posedge clk) begin
    if (rd_q) cmp_val(rdata, exp_r.pop_front());
    if (sv && exp_s.size() > 0) cmp_smp({sb, sa}, exp_s.pop_front());
    if (sv) vcnt <= vcnt + 1;
    rd_q <= rd;
  end

  // a constant pair: the halfband sums are exact powers of two, so dc passes unchanged
  task automatic stream(input int m, input logic [REG_W-1:0] ctl);
    logic [REG_W-1:0] p;
    int c0;
    p = $urandom;
    wr_reg(SAMPLE_OFS, p);
    rd_reg(SAMPLE_OFS, p);
    wr_reg(CTRL_OFS, ctl);
    repeat (400) @(posedge clk);
    repeat (8) exp_s.push_back(p);
    repeat (40) @(posedge clk);
    cmp_val(32'(exp_s.size()), 32'h0000_0000);
    @(negedge clk);
    c0 = vcnt;
    repeat (80) @(negedge clk);
    // ten pairs in 80 cycles, each pair yields 2, 4 or 8 samples for mode 0, 1 or 2
    cmp_val(32'(vcnt - c0), 32'(10 << (m + 1)));
    @(posedge clk);
    $display("stream test done, mode %0d", m);
  endtask

  initial begin
    int r;
    int c;
    r = $urandom(32'h4f92);
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd_reg(CTRL_OFS, CTRL_RESET);
    rd_reg(STATUS_OFS, 32'h0000_0000);
    rd_reg(4'hc, 32'h0000_0000);
    $display("reset test done");
    wr_reg(CTRL_OFS, 32'h0000_4000);
    c = 0;
    while (rdy !== 1'h1 && c < 500) begin
      @(posedge clk);
      c++;
    end
    cmp_val(32'(c >= 301 && c <= 330), 32'h0000_0001);
    rd_reg(STATUS_OFS, 32'h0000_0023);
    wr_reg(STATUS_OFS, 32'hffff_ffff);
    rd_reg(STATUS_OFS, 32'h0000_0023);
    $display("auto calibration test done");
    for (int m = 0; m < 3; m++) stream(m, 32'h0000_4000 | (m << CTRL_MODE_LSB));
    // switching to manual goes through a link reset so calibration runs again
    wr_reg(CTRL_OFS, 32'h0000_6211);
    stream(2, 32'h0000_4211);
    rd_reg(STATUS_OFS, 32'h0000_0013);
    stream(2, 32'h0000_4231);
    rd_reg(STATUS_OFS, 32'h0000_0033);
    wr_reg(CTRL_OFS, 32'h0000_42f1);
    repeat (4) @(posedge clk);
    rd_reg(STATUS_OFS, 32'h0000_00f3);
    $display("manual delay test done");
    conclude();
  end

  // the tests take some 3000 cycles; allow about three times that
  initial begin
    #(10000 * 100);
    num_errors++;
    conclude();
  end
endmodule
